// ===== gsc_gated_sampling.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module gsc_gated_sampling
    import gsc_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 20
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [31:0]       rd_data,
    input  wire logic              ext_trig,
    input  wire logic [DATA_W-1:0] ch_data,
    output logic                   store_valid,
    output logic      [DATA_W-1:0] store_data,
    output logic                   block_done,
    output logic                   acq_active,
    output logic                   acq_done
);

    // Elaboration check of parameters
    if (DATA_W != 8) begin : g_bad_data_w
        $error("gsc_gated_sampling: DATA_W must be 8");
    end
    if (ADDR_W < 20) begin : g_bad_addr_w
        $error("gsc_gated_sampling: ADDR_W must be at least 20");
    end

    typedef struct packed {
        gsc_state_t                          st;
        logic [31:0]                         total;
        logic                                gate_en;
        logic [3:0]                          mode;
        logic [7:0]                          pw;
        logic [7:0]                          hi;
        logic [7:0]                          lo;
        logic [1:0]                          chan;
        logic [1:0]                          rate;
        logic                                sync;
        logic                                fifo;
        logic [31:0]                         block_size;
        logic [31:0]                         stored;
        logic [31:0]                         block_cnt;
        logic [2:0]                          align;
        logic [5:0]                          dly;
        logic                                end_pend;
        logic [GSC_PIPE_DEPTH-1:0]           end_dly;
        logic                                cond_prev;
        logic [7:0]                          pw_cnt;
        logic                                mode_err;
        logic [GSC_PIPE_DEPTH-1:0][DATA_W-1:0] pipe;
        logic                                store_valid;
        logic [DATA_W-1:0]                   store_data;
        logic                                block_done;
        logic [31:0]                         rd_data;
    } gsc_regs_t;

    gsc_regs_t r_reg;
    gsc_regs_t r_next;

    // Start delay plus delay line depth less one, in sample cycles
    function automatic logic [5:0] gsc_start_cycles(
        input logic [1:0] chan,
        input logic [1:0] rate,
        input logic       ext,
        input logic       sync
    );
        int d;
        d = 0;
        if (chan[1] == 1'b0) begin
            unique case (rate)
                2'd0:    d = ext ? GSC_D_A_SLOW_EXT : GSC_D_A_SLOW_INT;
                2'd1:    d = ext ? GSC_D_A_MID_EXT : GSC_D_A_MID_INT;
                default: d = ext ? GSC_D_A_FAST_EXT : GSC_D_A_FAST_INT;
            endcase
        end else begin
            if (rate == 2'd0) begin
                d = ext ? GSC_D_B_SLOW_EXT : GSC_D_B_SLOW_INT;
            end else begin
                d = ext ? GSC_D_B_FAST_EXT : GSC_D_B_FAST_INT;
            end
        end
        if (sync) begin
            d = d + GSC_D_SYNC_ADD;
        end
        // Stored sample at the store edge is the one taken depth edges back
        return 6'(d + GSC_PIPE_DEPTH - 1);
    endfunction : gsc_start_cycles

    // Gate condition level for a mode code
    function automatic logic gsc_cond(
        input logic [3:0] mode,
        input logic       ext,
        input logic       above,
        input logic       inwin
    );
        logic c;
        c = 1'b0;
        unique case (mode)
            GSC_EXT_RISING_GATE, GSC_EXT_HIGH_PULSE_GATE:               c = ext;
            GSC_EXT_FALLING_GATE, GSC_EXT_LOW_PULSE_GATE:               c = ~ext;
            GSC_CHANNEL_RISING_GATE, GSC_CHANNEL_ABOVE_PULSE_GATE:      c = above;
            GSC_CHANNEL_FALLING_GATE, GSC_CHANNEL_BELOW_PULSE_GATE:     c = ~above;
            GSC_WINDOW_ENTER_GATE, GSC_WINDOW_ENTER_PULSE_GATE:         c = inwin;
            GSC_WINDOW_LEAVE_GATE, GSC_WINDOW_LEAVE_PULSE_GATE:         c = ~inwin;
            default:                                                    c = 1'b0;
        endcase
        return c;
    endfunction : gsc_cond

    // Decoded views of the current setup
    logic       mode_legal;
    logic       mode_pulse;
    logic       mode_ext;
    logic       above;
    logic       inwin;
    logic       cond;
    logic       gate_start;
    logic       gate_end;
    logic       limit_hit;
    logic [2:0] st_code;

    always_comb begin
        mode_legal = (r_reg.mode <= GSC_WINDOW_LEAVE_PULSE_GATE);
        mode_ext   = (r_reg.mode <= GSC_EXT_LOW_PULSE_GATE);
        mode_pulse = (r_reg.mode == GSC_EXT_HIGH_PULSE_GATE)
                  || (r_reg.mode == GSC_EXT_LOW_PULSE_GATE)
                  || (r_reg.mode == GSC_CHANNEL_ABOVE_PULSE_GATE)
                  || (r_reg.mode == GSC_CHANNEL_BELOW_PULSE_GATE)
                  || (r_reg.mode == GSC_WINDOW_ENTER_PULSE_GATE)
                  || (r_reg.mode == GSC_WINDOW_LEAVE_PULSE_GATE);
        above = (ch_data[7:0] > r_reg.hi);
        inwin = (ch_data[7:0] >= r_reg.lo) && (ch_data[7:0] <= r_reg.hi);
        cond  = gsc_cond(r_reg.mode, ext_trig, above, inwin);
        // Pulse modes open once held longer than the width
        if (mode_pulse) begin
            gate_start = cond && (r_reg.pw_cnt == r_reg.pw);
        end else begin
            gate_start = cond && !r_reg.cond_prev;
        end
        gate_end  = !cond && r_reg.cond_prev;
        limit_hit = !r_reg.fifo && (r_reg.stored + 32'd1 >= r_reg.total);
        st_code   = r_reg.st;
    end

    // Next-state logic for the whole block
    always_comb begin
        r_next             = r_reg;
        r_next.store_valid = 1'b0;
        r_next.block_done  = 1'b0;
        r_next.rd_data     = 32'h0000_0000;
        r_next.pipe        = {r_reg.pipe[GSC_PIPE_DEPTH-2:0], ch_data};
        r_next.cond_prev   = cond;
        // Gate ends travel with the samples, so they align with stored data
        r_next.end_dly     = {r_reg.end_dly[GSC_PIPE_DEPTH-2:0], gate_end};

        // Qualifier counter, saturating at 8'hff
        if (!cond) begin
            r_next.pw_cnt = 8'h00;
        end else if (r_reg.pw_cnt != 8'hff) begin
            r_next.pw_cnt = r_reg.pw_cnt + 8'h01;
        end

        // Acquisition sequencing
        unique case (r_reg.st)
            GSC_IDLE, GSC_DONE: begin
            end
            GSC_ARMED: begin
                if (!r_reg.gate_en || gate_start) begin
                    r_next.st       = GSC_DELAY;
                    r_next.dly      = gsc_start_cycles(r_reg.chan, r_reg.rate,
                                                       mode_ext, r_reg.sync);
                    r_next.end_pend = 1'b0;
                    r_next.end_dly  = '0;
                    r_next.align    = 3'h0;
                end
            end
            GSC_DELAY: begin
                if (r_reg.gate_en && r_reg.end_dly[GSC_PIPE_DEPTH-1]) begin
                    r_next.end_pend = 1'b1;
                end
                r_next.dly = r_reg.dly - 6'h01;
                if (r_reg.dly == 6'h01) begin
                    r_next.st = GSC_RECORD;
                end
            end
            GSC_RECORD: begin
                r_next.store_valid = 1'b1;
                r_next.store_data  = r_reg.pipe[GSC_PIPE_DEPTH-1];
                r_next.stored      = r_reg.stored + 32'd1;
                r_next.align       = r_reg.align + 3'h1;
                // Block boundary for streaming read-out
                if (r_reg.block_cnt + 32'd1 >= r_reg.block_size) begin
                    r_next.block_cnt  = 32'd0;
                    r_next.block_done = 1'b1;
                end else begin
                    r_next.block_cnt = r_reg.block_cnt + 32'd1;
                end
                if (r_reg.gate_en && r_reg.end_dly[GSC_PIPE_DEPTH-1]) begin
                    r_next.end_pend = 1'b1;
                end
                if (limit_hit) begin
                    r_next.st = GSC_DONE;
                end else if (r_reg.gate_en
                             && (r_reg.end_pend || r_reg.end_dly[GSC_PIPE_DEPTH-1])
                             && r_reg.align == GSC_ALIGN_LAST) begin
                    r_next.st = GSC_ARMED;
                end
            end
            default: r_next.st = GSC_IDLE;
        endcase

        // Register writes
        if (wr_en) begin
            unique case (addr[19:0])
                GSC_TOTAL_SAMPLE_COUNT_OFS: r_next.total      = wr_data;
                GSC_GATED_MODE_ENABLE_OFS:  r_next.gate_en    = wr_data[0];
                GSC_TRIGGER_MODE_OFS:       r_next.mode       = wr_data[3:0];
                GSC_UPPER_LEVEL_OFS:        r_next.hi         = wr_data[7:0];
                GSC_LOWER_LEVEL_OFS:        r_next.lo         = wr_data[7:0];
                GSC_PULSE_WIDTH_OFS:        r_next.pw         = wr_data[7:0];
                GSC_BLOCK_SIZE_OFS:         r_next.block_size = wr_data;
                GSC_SETUP_OFS: begin
                    r_next.chan = wr_data[GSC_SETUP_CHAN_LSB +: 2];
                    r_next.rate = wr_data[GSC_SETUP_RATE_LSB +: 2];
                    r_next.sync = wr_data[GSC_SETUP_SYNC_BIT];
                    r_next.fifo = wr_data[GSC_SETUP_FIFO_BIT];
                end
                GSC_COMMAND_OFS: begin
                    if (wr_data[GSC_CMD_STOP_BIT]) begin
                        r_next.st = GSC_IDLE;
                    end else if (wr_data[GSC_CMD_START_BIT]) begin
                        r_next.stored    = 32'd0;
                        r_next.block_cnt = 32'd0;
                        r_next.end_pend  = 1'b0;
                        if (r_reg.gate_en && !mode_legal) begin
                            r_next.mode_err = 1'b1;
                            r_next.st       = GSC_IDLE;
                        end else if (!r_reg.fifo && r_reg.total == 32'd0) begin
                            r_next.mode_err = 1'b0;
                            r_next.st       = GSC_DONE;
                        end else begin
                            r_next.mode_err = 1'b0;
                            r_next.st       = GSC_ARMED;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads, answered next cycle
        if (rd_en) begin
            unique case (addr[19:0])
                GSC_TOTAL_SAMPLE_COUNT_OFS: r_next.rd_data = r_reg.total;
                GSC_GATED_MODE_ENABLE_OFS:  r_next.rd_data = {31'd0, r_reg.gate_en};
                GSC_TRIGGER_MODE_OFS:       r_next.rd_data = {28'd0, r_reg.mode};
                GSC_UPPER_LEVEL_OFS:        r_next.rd_data = {24'd0, r_reg.hi};
                GSC_LOWER_LEVEL_OFS:        r_next.rd_data = {24'd0, r_reg.lo};
                GSC_PULSE_WIDTH_OFS:        r_next.rd_data = {24'd0, r_reg.pw};
                GSC_BLOCK_SIZE_OFS:         r_next.rd_data = r_reg.block_size;
                GSC_STORED_COUNT_OFS:       r_next.rd_data = r_reg.stored;
                GSC_SETUP_OFS: begin
                    r_next.rd_data[GSC_SETUP_CHAN_LSB +: 2] = r_reg.chan;
                    r_next.rd_data[GSC_SETUP_RATE_LSB +: 2] = r_reg.rate;
                    r_next.rd_data[GSC_SETUP_SYNC_BIT]      = r_reg.sync;
                    r_next.rd_data[GSC_SETUP_FIFO_BIT]      = r_reg.fifo;
                end
                GSC_STATUS_OFS: begin
                    r_next.rd_data[GSC_STAT_STATE_LSB +: 3] = st_code;
                    r_next.rd_data[GSC_STAT_ERR_BIT]        = r_reg.mode_err;
                end
                default: r_next.rd_data = 32'h0000_0000;
            endcase
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg            <= '0;
            r_reg.st         <= GSC_IDLE;
            r_reg.total      <= GSC_TOTAL_RST;
            r_reg.block_size <= GSC_BLOCK_RST;
            r_reg.pw         <= GSC_PW_RST;
            r_reg.hi         <= GSC_HI_RST;
            r_reg.lo         <= GSC_LO_RST;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from flip-flops; acq_active and acq_done decoded from the state
    always_comb begin
        rd_data     = r_reg.rd_data;
        store_valid = r_reg.store_valid;
        store_data  = r_reg.store_data;
        block_done  = r_reg.block_done;
        acq_active  = (r_reg.st == GSC_ARMED) || (r_reg.st == GSC_DELAY)
                   || (r_reg.st == GSC_RECORD);
        acq_done    = (r_reg.st == GSC_DONE);
    end

endmodule : gsc_gated_sampling

// ===== gsc_pkg.sv
package gsc_pkg;

    // Register byte offsets
    localparam logic [19:0] GSC_TOTAL_SAMPLE_COUNT_OFS = 20'h02710;
    localparam logic [19:0] GSC_GATED_MODE_ENABLE_OFS  = 20'h35cf0;
    localparam logic [19:0] GSC_TRIGGER_MODE_OFS       = 20'h09c40;
    localparam logic [19:0] GSC_UPPER_LEVEL_OFS        = 20'h0a410;
    localparam logic [19:0] GSC_LOWER_LEVEL_OFS        = 20'h0a474;
    localparam logic [19:0] GSC_PULSE_WIDTH_OFS        = 20'h0abe0;
    localparam logic [19:0] GSC_SETUP_OFS              = 20'h0c350;
    localparam logic [19:0] GSC_BLOCK_SIZE_OFS         = 20'h0c3b4;
    localparam logic [19:0] GSC_COMMAND_OFS            = 20'h0c418;
    localparam logic [19:0] GSC_STATUS_OFS             = 20'h0c47c;
    localparam logic [19:0] GSC_STORED_COUNT_OFS       = 20'h0c4e0;

    // Setup register field positions
    localparam int GSC_SETUP_CHAN_LSB = 0;
    localparam int GSC_SETUP_RATE_LSB = 2;
    localparam int GSC_SETUP_SYNC_BIT = 4;
    localparam int GSC_SETUP_FIFO_BIT = 5;

    // Command register bits
    localparam int GSC_CMD_START_BIT = 0;
    localparam int GSC_CMD_STOP_BIT  = 1;

    // Status register field positions
    localparam int GSC_STAT_STATE_LSB = 0;
    localparam int GSC_STAT_ERR_BIT   = 4;

    // Reset values
    localparam logic [31:0] GSC_TOTAL_RST = 32'h0000_1000;
    localparam logic [31:0] GSC_BLOCK_RST = 32'h0000_0400;
    localparam logic [7:0]  GSC_PW_RST    = 8'h02;
    localparam logic [7:0]  GSC_HI_RST    = 8'hc0;
    localparam logic [7:0]  GSC_LO_RST    = 8'h40;

    // Sample delay line depth; absorbs negative start delays
    localparam int GSC_PIPE_DEPTH = 8;
    // Gate end is honoured only on the store where align equals this, the last of each group of eight
    localparam logic [2:0] GSC_ALIGN_LAST = 3'h7;

    // Gate condition codes written to the trigger mode register
    localparam logic [3:0] GSC_EXT_RISING_GATE            = 4'h0;
    localparam logic [3:0] GSC_EXT_FALLING_GATE           = 4'h1;
    localparam logic [3:0] GSC_EXT_HIGH_PULSE_GATE        = 4'h2;
    localparam logic [3:0] GSC_EXT_LOW_PULSE_GATE         = 4'h3;
    localparam logic [3:0] GSC_CHANNEL_RISING_GATE        = 4'h4;
    localparam logic [3:0] GSC_CHANNEL_FALLING_GATE       = 4'h5;
    localparam logic [3:0] GSC_CHANNEL_ABOVE_PULSE_GATE   = 4'h6;
    localparam logic [3:0] GSC_CHANNEL_BELOW_PULSE_GATE   = 4'h7;
    localparam logic [3:0] GSC_WINDOW_ENTER_GATE          = 4'h8;
    localparam logic [3:0] GSC_WINDOW_ENTER_PULSE_GATE    = 4'h9;
    localparam logic [3:0] GSC_WINDOW_LEAVE_GATE          = 4'ha;
    localparam logic [3:0] GSC_WINDOW_LEAVE_PULSE_GATE    = 4'hb;

    // Start delays in samples, indexed by setup
    localparam int GSC_D_A_SLOW_EXT = 22;
    localparam int GSC_D_A_SLOW_INT = 31;
    localparam int GSC_D_A_MID_EXT  = 23;
    localparam int GSC_D_A_MID_INT  = 21;
    localparam int GSC_D_A_FAST_EXT = 16;
    localparam int GSC_D_A_FAST_INT = 32;
    localparam int GSC_D_B_SLOW_EXT = -5;
    localparam int GSC_D_B_SLOW_INT = 5;
    localparam int GSC_D_B_FAST_EXT = 8;
    localparam int GSC_D_B_FAST_INT = 16;
    localparam int GSC_D_SYNC_ADD   = 2;

    typedef enum logic [2:0] {
        GSC_IDLE,
        GSC_ARMED,
        GSC_DELAY,
        GSC_RECORD,
        GSC_DONE
    } gsc_state_t;

endpackage : gsc_pkg

// ===== gsc_gated_sampling_monitor.sv
`timescale 1ns/1ps
module gsc_gated_sampling_monitor #(
    parameter int DATA_W = 8
) (
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              wr_en,
    input wire logic              rd_en,
    input wire logic              ce,
    input wire logic [31:0]       rd_data,
    input wire logic [DATA_W-1:0] ch_data,
    input wire logic              store_valid,
    input wire logic [DATA_W-1:0] store_data,
    input wire logic              block_done,
    input wire logic              acq_active,
    input wire logic              acq_done
);
    logic [2:0] run_q;

    // Length of the current stored run, modulo eight
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            run_q <= 3'h0;
        else if (store_valid)
            run_q <= run_q + 3'h1;
        else
            run_q <= 3'h0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // A stored run ends while the block stays armed
    sequence s_seg_end;
        $fell(store_valid) && acq_active;
    endsequence

    a_seg_align: assert property (s_seg_end |-> run_q == 3'h0)
        else $error("Stored run length not a multiple of eight");
    a_pause_gap: assert property (s_seg_end |=> !store_valid [*3])
        else $error("Storage resumed too soon after a pause");
    a_read_idle: assert property (!$past(rd_en && ce) |-> rd_data == 32'h0)
        else $error("Read data present without a read");
    a_store_latency: assert property (store_valid |-> store_data == $past(ch_data, 9))
        else $error("Stored sample does not match the sample stream");
    a_store_active: assert property (store_valid |-> $past(acq_active))
        else $error("Sample stored outside an acquisition");
    a_done_quiet: assert property (acq_done && $past(acq_done) |-> !store_valid)
        else $error("Sample stored after the limit");
    a_done_holds: assert property (acq_done && !wr_en |=> acq_done)
        else $error("Finished state left without a command");
    a_done_cause: assert property ($rose(acq_done) |-> store_valid || $past(wr_en))
        else $error("Finished without a final stored sample");
    a_block_store: assert property (block_done |-> store_valid)
        else $error("Block end without a stored sample");
endmodule : gsc_gated_sampling_monitor

bind gsc_gated_sampling gsc_gated_sampling_monitor #(.DATA_W(DATA_W)) u_mon (
    .clk, .reset_n, .wr_en, .rd_en, .ce, .rd_data, .ch_data, .store_valid,
    .store_data, .block_done, .acq_active, .acq_done);

// ===== gsc_gate_source.sv
`timescale 1ns/1ps
module gsc_gate_source (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       gate_req,
    input wire logic       toggle_en,
    output logic           ext_trig,
    output logic [7:0]     ch_data
);
    logic [5:0] tog_cnt;

    // Ramp on the channel, gate level or square wave on the trigger
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ch_data <= 8'h00;
            tog_cnt <= 6'h00;
            ext_trig <= 1'b0;
        end else begin
            ch_data <= ch_data + 8'h01;
            tog_cnt <= (tog_cnt == 6'h27) ? 6'h00 : tog_cnt + 6'h01;
            if (!toggle_en)
                ext_trig <= gate_req;
            else if (tog_cnt == 6'h27)
                ext_trig <= !ext_trig;
        end
    end
endmodule : gsc_gate_source

// ===== test_gsc_gated_sampling.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_gsc_gated_sampling import gsc_pkg::*;;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [19:0] addr = 20'h0;
    logic [31:0] wr_data = 32'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        gate_req = 1'b0;
    logic        toggle_en = 1'b0;
    logic [31:0] rd_data, rv;
    logic        ext_trig, store_valid, block_done, acq_active, acq_done;
    logic [7:0]  ch_data, store_data, seg_first, trig_val;
    logic        sv_q = 1'b0;
    logic        et_q = 1'b0;
    int num_errors = 0, n_tests = 0, n_stored = 0, n_blocks = 0;
    int run = 0, last_run = 0, cyc = 0, base, bb, idx;
    logic [31:0] setups [6] = '{32'h00, 32'h10, 32'h05, 32'h02, 32'h12, 32'h06};
    int dly [6] = '{22, 24, 23, -5, -3, 8};

    always #5 clk = ~clk;

    gsc_gated_sampling dut (.clk, .reset_n, .ce(1'b1), .addr, .wr_data, .wr_en, .rd_en,
        .rd_data, .ext_trig, .ch_data, .store_valid, .store_data, .block_done,
        .acq_active, .acq_done);
    gsc_gate_source partner (.clk, .reset_n, .gate_req, .toggle_en, .ext_trig, .ch_data);

    // Observe gate starts, stored runs and blocks; cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (ext_trig && !et_q) trig_val = ch_data;
        et_q = ext_trig;
        if (store_valid && !sv_q) seg_first = store_data;
        if (store_valid) begin
            n_stored++;
            run++;
        end else if (sv_q) begin
            last_run = run;
            run = 0;
        end
        sv_q = store_valid;
        if (block_done) n_blocks++;
        if (cyc == 40000) begin
            num_errors++;
            close_out();
        end
    end

    // Called just after a rising edge; leaves one idle edge before returning
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic chk_rd(input logic [19:0] a, input logic [31:0] e);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 rv = rd_data;
        @(posedge clk);
        `CHK(rv, e)
    endtask : chk_rd

    task automatic arm(input logic [31:0] setup, input logic [3:0] mode, input logic [31:0] tot);
        wr(GSC_COMMAND_OFS, 32'h2);
        wr(GSC_SETUP_OFS, setup);
        wr(GSC_TRIGGER_MODE_OFS, {28'h0, mode});
        wr(GSC_TOTAL_SAMPLE_COUNT_OFS, tot);
        wr(GSC_COMMAND_OFS, 32'h1);
        repeat (4) @(posedge clk);
    endtask : arm

    task automatic close_out;
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        `CHK(acq_active, 1'b0)
        chk_rd(GSC_TOTAL_SAMPLE_COUNT_OFS, GSC_TOTAL_RST);
        chk_rd(GSC_GATED_MODE_ENABLE_OFS, 32'h0);
        chk_rd(20'h00004, 32'h0);
        wr(GSC_TOTAL_SAMPLE_COUNT_OFS, 32'h1234_5678);
        chk_rd(GSC_TOTAL_SAMPLE_COUNT_OFS, 32'h1234_5678);
        wr(GSC_GATED_MODE_ENABLE_OFS, 32'h1);
        chk_rd(GSC_GATED_MODE_ENABLE_OFS, 32'h1);
        // Start delay and end alignment per setup, two gates each
        for (int i = 0; i < 6; i++) begin
            arm(setups[i], GSC_EXT_RISING_GATE, 32'hffff);
            idx = 3 - dly[i];
            for (int g = 0; g < 2; g++) begin
                @(posedge clk);
                gate_req <= 1'b1;
                repeat (3) @(posedge clk);
                gate_req <= 1'b0;
                repeat (90) @(posedge clk);
                `CHK(seg_first, 8'(trig_val + dly[i]))
                `CHK(last_run, (idx < 0) ? 8 : (idx / 8 + 1) * 8)
            end
        end
        // Channel crossing with internal start delay
        arm(32'h0, GSC_CHANNEL_RISING_GATE, 32'hffff);
        repeat (600) @(posedge clk);
        `CHK(seg_first, 8'he0)
        `CHK(last_run, 40)
        // Total count reached with the gate still open
        base = n_stored;
        arm(32'h0, GSC_EXT_RISING_GATE, 32'h5);
        gate_req <= 1'b1;
        repeat (100) @(posedge clk);
        gate_req <= 1'b0;
        `CHK(n_stored - base, 5)
        `CHK(acq_done, 1'b1)
        chk_rd(GSC_STATUS_OFS, 32'h4);
        // Unlisted gate condition is refused
        arm(32'h0, 4'hc, 32'hffff);
        chk_rd(GSC_STATUS_OFS, 32'h10);
        `CHK(acq_active, 1'b0)
        // Every listed gate condition records
        wr(GSC_PULSE_WIDTH_OFS, 32'h2);
        toggle_en <= 1'b1;
        for (int m = 0; m < 12; m++) begin
            base = n_stored;
            arm(32'h0, 4'(m), 32'hffff);
            repeat (700) @(posedge clk);
            `CHK(n_stored > base, 1'b1)
        end
        toggle_en <= 1'b0;
        // Streaming ignores the total and runs until stopped
        base = n_stored;
        bb = n_blocks;
        wr(GSC_BLOCK_SIZE_OFS, 32'h8);
        arm(32'h20, GSC_EXT_RISING_GATE, 32'h4);
        gate_req <= 1'b1;
        repeat (100) @(posedge clk);
        `CHK(n_stored - base > 4, 1'b1)
        `CHK(n_blocks > bb, 1'b1)
        `CHK(acq_active, 1'b1)
        wr(GSC_COMMAND_OFS, 32'h2);
        gate_req <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(acq_active, 1'b0)
        close_out();
    end
endmodule : test_gsc_gated_sampling
